// ### ncafe_pkg.sv
// package with command codes, address layout and timing counts for the flash host front end
package ncafe_pkg;
    // command codes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
    localparam logic [7:0] CMD_COL_OUT = 8'h05;
    localparam logic [7:0] CMD_COL_OUT_CONFIRM = 8'hE0;
    localparam logic [7:0] CMD_DATA_IN = 8'h80;
    localparam logic [7:0] CMD_PROGRAM = 8'h10;
    localparam logic [7:0] CMD_COL_IN = 8'h85;
    localparam logic [7:0] CMD_MULTI_FIRST = 8'h11;
    localparam logic [7:0] CMD_MULTI_SECOND = 8'h81;
    localparam logic [7:0] CMD_COPY_READ = 8'h35;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_ID_READ = 8'h90;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;
    localparam logic [7:0] CMD_ECC_STATUS = 8'h7A;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    // address geometry
    localparam int COL_W = 13;
    localparam int ROW_W = 17;
    localparam int PAGE_W = 6;
    localparam int BLOCK_W = 11;
    localparam int PAGE_BYTES = 4224;
    localparam int MAIN_BYTES = 4096;
    localparam int SPARE_BYTES = 128;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int BLOCKS = 2048;
    localparam int BLOCKS_PER_DISTRICT = 1024;
    localparam int ADDR_CYCLES = 5;
    // pin timing, each strobe phase lasts this long
    localparam int CLK_MHZ = 40;
    localparam int PHASE_NS = 50;
    localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam int WHR_NS = 60;
    localparam int WHR_CYC = (WHR_NS * CLK_MHZ + 999) / 1000;
    localparam int WB_NS = 100;
    localparam int WB_CYC = (WB_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] WB_CYC4 = 4'(WB_CYC);
endpackage

// ### ncafe_pace.sv
`timescale 1ns/100ps
// phase pacing divider: one-cycle tick every PHASE_CYC cycles while running
module ncafe_pace
    import ncafe_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic run,
    output logic tick
);
    logic [3:0] cnt_reg;

    // count up while running, pulse on reaching PHASE_CYC-1 and restart from zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_reg <= 4'h0;
            tick <= 1'b0;
        end else if (!run) begin
            cnt_reg <= 4'h0;
            tick <= 1'b0;
        end else if (cnt_reg == 4'(PHASE_CYC - 1)) begin
            cnt_reg <= 4'h0;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
            tick <= 1'b0;
        end
    end
endmodule

// ### ncafe_host.sv
`timescale 1ns/100ps
// host controller that drives the flash command, address and data pins
// How it works
// - all five address bytes are sent as write-strobed cycles in order
// - column bits 7:0 then 12:8, upper three lines of byte two low
// - row page 5:0 and block 16:6 over bytes three to five, byte five bit0 only
// - latches set cycle kind: command, address, data input needs protect high
// - while device busy with chip select low, keep both strobes high except for 70h, 71h and FFh commands
// - page read is 00h, five address bytes, then 30h
// - multi-page read uses the same page bits 5:0 in both districts
// - 7Ah only after a single-page read, never after multi-page read
module ncafe_host
    import ncafe_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // request: kind 0 command, 1 address, 2 data write, 3 data read
    input wire logic req_valid,
    input wire logic [1:0] req_kind,
    input wire logic [7:0] req_byte,
    input wire logic req_multi_read,
    output logic req_ready,
    // answers
    output logic rsp_valid,
    output logic [7:0] rsp_byte,
    output logic rsp_refused,
    output logic multi_read_reg,
    // protect control
    input wire logic protect_off,
    // flash pins
    output logic chip_sel_n,
    output logic cmd_latch,
    output logic addr_latch,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic write_prot_n,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic [7:0] io_in,
    input wire logic ready_busy_n
);
    typedef enum logic [2:0] {
        NCAFE_IDLE = 3'b000,
        NCAFE_WLOW = 3'b001,
        NCAFE_WHIGH = 3'b010,
        NCAFE_RLOW = 3'b011,
        NCAFE_RHIGH = 3'b100,
        NCAFE_BUSYW = 3'b101
    } ncafe_state_e;

    ncafe_state_e state_reg;
    logic tick;
    logic [7:0] cmd_reg;
    logic [3:0] wb_reg;
    logic [2:0] addr_cnt_reg;
    logic [7:0] io_meta_reg, io_sync_reg;
    logic rb_meta_reg, rb_sync_reg;
    logic single_read_reg;

    // classify a command byte the host may issue while the device is busy
    function automatic logic busy_ok(input logic [7:0] c);
        busy_ok = (c == CMD_STATUS) || (c == CMD_STATUS_MULTI) || (c == CMD_RESET);
    endfunction

    // refuse a request the device would ignore or that breaks the pin contract
    function automatic logic refuse(input logic [1:0] k, input logic [7:0] c, input logic busy, input logic mr,
                                    input logic sr);
        logic r;
        r = 1'b0;
        if (busy && !(k == 2'd0 && busy_ok(c))) begin
            r = 1'b1;
        end
        if (k == 2'd0 && c == CMD_ECC_STATUS && (mr || !sr)) begin
            r = 1'b1;
        end
        refuse = r;
    endfunction

    ncafe_pace u_pace (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(state_reg != NCAFE_IDLE),
        .tick(tick)
    );

    // two-flop synchronisers for the bus and ready line
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            io_meta_reg <= 8'h00;
            io_sync_reg <= 8'h00;
            // ready line is pulled up, so start at its idle level to avoid a false busy
            rb_meta_reg <= 1'b1;
            rb_sync_reg <= 1'b1;
        end else begin
            io_meta_reg <= io_in;
            io_sync_reg <= io_meta_reg;
            rb_meta_reg <= ready_busy_n;
            rb_sync_reg <= rb_meta_reg;
        end
    end

    // protect pin follows software, forced high whenever the synchronised ready line shows busy
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            write_prot_n <= 1'b0;
        end else begin
            write_prot_n <= protect_off || !rb_sync_reg;
        end
    end

    // strobe sequencer: one phase low, one phase high per byte
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= NCAFE_IDLE;
            cmd_reg <= CMD_READ;
            chip_sel_n <= 1'b1;
            cmd_latch <= 1'b0;
            addr_latch <= 1'b0;
            write_strobe_n <= 1'b1;
            read_strobe_n <= 1'b1;
            io_out <= 8'h00;
            io_oe <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_byte <= 8'h00;
            rsp_refused <= 1'b0;
            wb_reg <= 4'h0;
        end else begin
            rsp_valid <= 1'b0;
            rsp_refused <= 1'b0;
            unique case (state_reg)
                NCAFE_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        req_ready <= 1'b0;
                        if (refuse(req_kind, req_byte, !rb_sync_reg, multi_read_reg, single_read_reg)) begin
                            rsp_refused <= 1'b1;
                            rsp_valid <= 1'b1;
                        end else if (req_kind == 2'd2 && !write_prot_n) begin
                            rsp_refused <= 1'b1;
                            rsp_valid <= 1'b1;
                        end else begin
                            chip_sel_n <= 1'b0;
                            cmd_latch <= (req_kind == 2'd0);
                            addr_latch <= (req_kind == 2'd1);
                            io_out <= req_byte;
                            // unused upper lines of address bytes two and five always go out low
                            if (req_kind == 2'd1 && addr_cnt_reg == 3'h1) begin
                                io_out <= {3'h0, req_byte[4:0]};
                            end
                            if (req_kind == 2'd1 && addr_cnt_reg == 3'h4) begin
                                io_out <= {7'h00, req_byte[0]};
                            end
                            io_oe <= (req_kind != 2'd3);
                            if (req_kind == 2'd0) begin
                                cmd_reg <= req_byte;
                            end
                            if (req_kind == 2'd3) begin
                                read_strobe_n <= 1'b0;
                                state_reg <= NCAFE_RLOW;
                            end else begin
                                write_strobe_n <= 1'b0;
                                state_reg <= NCAFE_WLOW;
                            end
                        end
                    end
                end
                NCAFE_WLOW: begin
                    if (tick) begin
                        write_strobe_n <= 1'b1;
                        state_reg <= NCAFE_WHIGH;
                    end
                end
                NCAFE_WHIGH: begin
                    if (tick) begin
                        cmd_latch <= 1'b0;
                        addr_latch <= 1'b0;
                        io_oe <= 1'b0;
                        wb_reg <= WB_CYC4;
                        state_reg <= NCAFE_BUSYW;
                    end
                end
                NCAFE_RLOW: begin
                    if (tick) begin
                        rsp_byte <= io_sync_reg;
                        read_strobe_n <= 1'b1;
                        state_reg <= NCAFE_RHIGH;
                    end
                end
                NCAFE_RHIGH: begin
                    if (tick) begin
                        rsp_valid <= 1'b1;
                        state_reg <= NCAFE_IDLE;
                    end
                end
                NCAFE_BUSYW: begin
                    // wait out the write-to-busy delay so busy is seen before the next byte
                    if (wb_reg != 4'h0) begin
                        wb_reg <= wb_reg - 4'h1;
                    end else begin
                        rsp_valid <= 1'b1;
                        state_reg <= NCAFE_IDLE;
                    end
                end
                default: begin
                    state_reg <= NCAFE_IDLE;
                end
            endcase
        end
    end

    // address byte counter, restarts on every command byte
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_cnt_reg <= 3'd0;
        end else if (state_reg == NCAFE_WLOW && tick) begin
            if (cmd_latch) begin
                addr_cnt_reg <= 3'd0;
            end else if (addr_latch && addr_cnt_reg != 3'(ADDR_CYCLES)) begin
                addr_cnt_reg <= addr_cnt_reg + 3'd1;
            end
        end
    end

    // track single versus multi-page read for the ECC status gate
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            multi_read_reg <= 1'b0;
            single_read_reg <= 1'b0;
        end else if (state_reg == NCAFE_WLOW && tick && cmd_latch) begin
            if (cmd_reg == CMD_READ_CONFIRM) begin
                multi_read_reg <= req_multi_read;
                single_read_reg <= !req_multi_read;
            end else if (cmd_reg != CMD_STATUS && cmd_reg != CMD_STATUS_MULTI && cmd_reg != CMD_ECC_STATUS) begin
                multi_read_reg <= 1'b0;
                single_read_reg <= 1'b0;
            end
        end
    end

    // strobes stay high for address, data and read requests while the device is busy
    a_busy_strobes: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == NCAFE_IDLE && req_valid && req_ready && !rb_sync_reg && req_kind != 2'd0)
        |=> rsp_refused && write_strobe_n && read_strobe_n) else $error("strobe issued while busy");
    a_busy_cmd_filter: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == NCAFE_IDLE && req_valid && req_ready && !rb_sync_reg && req_kind == 2'd0 && !busy_ok(req_byte))
        |=> rsp_refused) else $error("disallowed command while busy");
    a_ecc_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == NCAFE_IDLE && req_valid && req_ready && req_kind == 2'd0 && req_byte == CMD_ECC_STATUS
         && multi_read_reg) |=> rsp_refused) else $error("ecc status after multi read");
    a_cmd_latch_kind: assert property (@(posedge clk_sys) disable iff (rst)
        !write_strobe_n |-> !chip_sel_n && read_strobe_n && (cmd_latch != addr_latch || io_oe))
        else $error("bad write cycle pins");
    a_wstrobe_width: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(write_strobe_n) |-> !write_strobe_n [*2]) else $error("write strobe too short");
    a_data_protect: assert property (@(posedge clk_sys) disable iff (rst)
        (!write_strobe_n && !cmd_latch && !addr_latch) |-> write_prot_n) else $error("data in while protected");
    a_read_no_drive: assert property (@(posedge clk_sys) disable iff (rst)
        !read_strobe_n |-> !io_oe && write_strobe_n) else $error("host drives bus during read");
    // a read confirm goes out only once all five address bytes have been sent
    a_addr_count: assert property (@(posedge clk_sys) disable iff (rst)
        (state_reg == NCAFE_WLOW && tick && cmd_latch && cmd_reg == CMD_READ_CONFIRM)
        |-> addr_cnt_reg == 3'(ADDR_CYCLES)) else $error("read confirm before five address bytes");
    a_power_on_read: assert property (@(posedge clk_sys)
        $fell(rst) |-> cmd_reg == CMD_READ) else $error("command not 00h after reset");
endmodule

// ### ncafe_flash_model.sv
// behavioural flash device model facing the host front end pins
`timescale 1ns/100ps
module ncafe_flash_model
    import ncafe_pkg::*;
#(
    parameter int BUSY_NS = 3000,
    parameter int WB_DLY = 40
)
(
    // control pins
    input wire logic chip_sel_n,
    input wire logic cmd_latch,
    input wire logic addr_latch,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic write_prot_n,
    // data bus and busy line
    input wire logic [7:0] io_bus,
    output logic [7:0] io_dev,
    output logic ready_busy_n,
    // observation of what reached the device
    output logic [7:0] last_cmd,
    output logic [7:0] data_in
);
    logic [7:0] cmd_reg = 8'h00;
    logic [7:0] abyte [0:4];
    int acnt = 0;
    logic [COL_W-1:0] column_addr = '0;
    logic [ROW_W-1:0] row_addr = '0;
    logic out_sel = 1'b0;
    event go_busy;
    initial begin
        io_dev = 8'hA5;
        ready_busy_n = 1'b1;
        last_cmd = 8'h00;
        data_in = 8'h00;
    end
    // array transfer: busy shortly after the confirm strobe, ready when done
    always @(go_busy) begin
        #(WB_DLY) ready_busy_n = 1'b0;
        #(BUSY_NS) ready_busy_n = 1'b1;
    end
    // latch command, address or data on the write strobe rise
    always @(posedge write_strobe_n) begin
        if (!chip_sel_n && read_strobe_n) begin
            if (cmd_latch && !addr_latch) begin
                last_cmd = io_bus;
                if (ready_busy_n || io_bus inside {8'h70, 8'h71, 8'hFF}) begin
                    if (io_bus == CMD_READ_CONFIRM && cmd_reg == CMD_READ) begin
                        ->go_busy;
                    end
                    if (io_bus == CMD_COL_OUT_CONFIRM) begin
                        column_addr = {abyte[1][4:0], abyte[0]};
                    end
                    if (io_bus inside {CMD_READ, CMD_READ_CONFIRM, CMD_COL_OUT, CMD_COL_OUT_CONFIRM, CMD_DATA_IN,
                        CMD_PROGRAM, CMD_COL_IN, CMD_MULTI_FIRST, CMD_MULTI_SECOND, CMD_COPY_READ, CMD_ERASE,
                        CMD_ERASE_CONFIRM, CMD_ID_READ, CMD_STATUS, CMD_STATUS_MULTI, CMD_ECC_STATUS, CMD_RESET}) begin
                        cmd_reg = io_bus;
                        out_sel = (io_bus == CMD_STATUS) || (io_bus == CMD_STATUS_MULTI);
                        acnt = 0;
                    end
                end
            end else if (addr_latch && !cmd_latch && acnt < ADDR_CYCLES) begin
                abyte[acnt] = io_bus;
                acnt++;
                if (acnt == ADDR_CYCLES) begin
                    column_addr = {abyte[1][4:0], abyte[0]};
                    row_addr = {abyte[4][0], abyte[3], abyte[2]};
                end
            end else if (!cmd_latch && !addr_latch && write_prot_n) begin
                data_in = io_bus;
            end
        end
    end
    // drive status or the next page byte on read strobe fall
    always @(negedge read_strobe_n) begin
        if (!chip_sel_n && !cmd_latch && !addr_latch && write_strobe_n) begin
            #5 io_dev = out_sel ? {write_prot_n, ready_busy_n, ready_busy_n, 5'h00} :
                column_addr[7:0] ^ row_addr[7:0] ^ row_addr[15:8] ^ {7'h00, row_addr[16]};
            if (!out_sel) column_addr = column_addr + 1'b1;
        end
    end
    // released bus shows the inverse of the last value, never a stale byte
    always @(posedge read_strobe_n) io_dev = ~io_dev;
endmodule

// ### ncafe_tb.sv
// self-checking testbench for the flash host front end
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module testbench
    import ncafe_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [1:0] req_kind = 2'h0;
    logic [7:0] req_byte = 8'h00;
    logic req_multi_read = 1'b0;
    logic protect_off = 1'b1;
    logic req_ready, rsp_valid, rsp_refused, multi_read_reg, io_oe, ready_busy_n;
    logic chip_sel_n, cmd_latch, addr_latch, write_strobe_n, read_strobe_n, write_prot_n;
    logic [7:0] rsp_byte, io_out, io_dev, io_bus, last_cmd, data_in;
    int n_checks = 0;
    int n_mismatch = 0;
    // one bus: host drives when enabled, else the device
    assign io_bus = io_oe ? io_out : io_dev;
    // clock at 40 MHz
    always #12.5 clk_sys = ~clk_sys;
    ncafe_host dut_u (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_kind(req_kind),
        .req_byte(req_byte), .req_multi_read(req_multi_read), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_byte(rsp_byte), .rsp_refused(rsp_refused), .multi_read_reg(multi_read_reg),
        .protect_off(protect_off), .chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .write_prot_n(write_prot_n),
        .io_out(io_out), .io_oe(io_oe), .io_in(io_bus), .ready_busy_n(ready_busy_n));
    ncafe_flash_model flash_u (.chip_sel_n(chip_sel_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .write_prot_n(write_prot_n),
        .io_bus(io_bus), .io_dev(io_dev), .ready_busy_n(ready_busy_n), .last_cmd(last_cmd), .data_in(data_in));
    // verdict and end of run
    task automatic complete_run;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tmo;
        n_mismatch++;
        complete_run();
    endtask
    // expected page byte for a column and row
    function automatic logic [7:0] pat(input logic [12:0] c, input logic [16:0] r);
        return c[7:0] ^ r[7:0] ^ r[15:8] ^ {7'h00, r[16]};
    endfunction
    // one request: held until taken, then wait for the answer
    task automatic send(input logic [1:0] k, input logic [7:0] b, input logic m, input logic rf);
        int i;
        i = 0;
        @(negedge clk_sys);
        req_valid = 1'b1;
        req_kind = k;
        req_byte = b;
        req_multi_read = m;
        for (i = 0; req_ready !== 1'b1; i++) begin
            if (i > 200) tmo();
            @(negedge clk_sys);
        end
        i = 0;
        do begin
            @(negedge clk_sys);
            req_valid = 1'b0;
            i++;
            if (i > 400) tmo();
        end while (rsp_valid !== 1'b1);
        `CHK("refused", rf, rsp_refused)
    endtask
    task automatic cmd(input logic [7:0] b, input logic rf);
        send(2'h0, b, 1'b0, rf);
    endtask
    task automatic addr5(input logic [12:0] c, input logic [16:0] r);
        send(2'h1, c[7:0], 1'b0, 1'b0);
        send(2'h1, {3'h0, c[12:8]}, 1'b0, 1'b0);
        send(2'h1, r[7:0], 1'b0, 1'b0);
        send(2'h1, r[15:8], 1'b0, 1'b0);
        send(2'h1, {7'h00, r[16]}, 1'b0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] e);
        send(2'h3, 8'h00, 1'b0, 1'b0);
        `CHK("read byte", e, rsp_byte)
    endtask
    task automatic wait_ready;
        int i;
        for (i = 0; ready_busy_n !== 1'b1; i++) begin
            if (i > 400) tmo();
            @(negedge clk_sys);
        end
        repeat (4) @(negedge clk_sys);
    endtask
    // power-on read needs only address and confirm; ECC status only before the next command
    task automatic t_first_read;
        addr5(13'h107E, 17'h1_2341);
        cmd(CMD_READ_CONFIRM, 1'b0);
        `CHK("busy", 1'b0, ready_busy_n)
        wait_ready();
        cmd(CMD_ECC_STATUS, 1'b0);
        rd(pat(13'h107E, 17'h1_2341));
        rd(pat(13'h107F, 17'h1_2341));
        cmd(CMD_COL_OUT, 1'b0);
        send(2'h1, 8'h23, 1'b0, 1'b0);
        send(2'h1, 8'h01, 1'b0, 1'b0);
        cmd(CMD_COL_OUT_CONFIRM, 1'b0);
        rd(pat(13'h0123, 17'h1_2341));
        cmd(CMD_ECC_STATUS, 1'b1);
    endtask
    // only status and reset commands pass while busy, others never reach the pins; protect held high
    task automatic t_busy;
        cmd(CMD_READ, 1'b0);
        addr5(13'h0000, 17'h0_0005);
        cmd(CMD_READ_CONFIRM, 1'b0);
        protect_off = 1'b0;
        cmd(CMD_DATA_IN, 1'b1);
        send(2'h1, 8'h00, 1'b0, 1'b1);
        `CHK("cmd seen", CMD_READ_CONFIRM, last_cmd)
        cmd(CMD_STATUS_MULTI, 1'b0);
        cmd(CMD_STATUS, 1'b0);
        `CHK("cmd seen", CMD_STATUS, last_cmd)
        `CHK("protect", 1'b1, write_prot_n)
        protect_off = 1'b1;
        wait_ready();
        rd(8'hE0);
    endtask
    // multi-page read over both districts, then ECC status is refused
    task automatic t_multi;
        cmd(CMD_READ, 1'b0);
        addr5(13'h0000, 17'h0_0045);
        cmd(CMD_READ, 1'b0);
        addr5(13'h0000, 17'h0_0085);
        send(2'h0, CMD_READ_CONFIRM, 1'b1, 1'b0);
        `CHK("multi", 1'b1, multi_read_reg)
        wait_ready();
        rd(pat(13'h0000, 17'h0_0085));
        cmd(CMD_ECC_STATUS, 1'b1);
    endtask
    // data input refused while protected, taken once released
    task automatic t_protect;
        protect_off = 1'b0;
        repeat (4) @(negedge clk_sys);
        `CHK("protect", 1'b0, write_prot_n)
        cmd(CMD_DATA_IN, 1'b0);
        addr5(13'h0010, 17'h0_0040);
        send(2'h2, 8'h3C, 1'b0, 1'b1);
        protect_off = 1'b1;
        repeat (4) @(negedge clk_sys);
        send(2'h2, 8'h5A, 1'b0, 1'b0);
        `CHK("data in", 8'h5A, data_in)
    endtask
    // main sequence
    initial begin
        repeat (10) @(negedge clk_sys);
        `CHK("cs", 1'b1, chip_sel_n)
        `CHK("protect", 1'b0, write_prot_n)
        `CHK("oe", 1'b0, io_oe)
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        t_first_read();
        t_busy();
        t_multi();
        t_protect();
        complete_run();
    end
endmodule
